/* File: core/flash_self_program_pkg.sv */
// constants for the flash self-programming control block
// assumes a 32-bit apb master and a single clock domain
package flash_self_program_pkg;

    // register byte offsets
    localparam logic [11:0] protect_command_offset = 12'h000;
    localparam logic [11:0] mode_control_offset = 12'h004;
    localparam logic [11:0] system_status_offset = 12'h008;
    localparam logic [11:0] routine_request_offset = 12'h00C;
    localparam logic [11:0] routine_argument_offset = 12'h010;
    localparam logic [11:0] routine_result_offset = 12'h014;
    localparam logic [11:0] cell_status_offset = 12'h018;

    // mode control fields
    localparam int self_program_bit = 1;
    localparam int voltage_detect_bit = 2;
    localparam int program_disable_bit_pos = 3;
    localparam int fixed_one_bit = 4;
    localparam int spare_bit = 5;
    localparam logic [7:0] mode_control_reset = 8'h18;
    localparam logic [7:0] mode_control_write_mask = 8'h2A;

    // system status fields
    localparam int protection_error_pos = 0;

    // result codes, zero means success
    localparam logic [31:0] result_ok = 32'h00000000;
    localparam logic [31:0] result_overerase = 32'h00000001;
    localparam logic [31:0] result_undererase = 32'h00000002;
    localparam logic [31:0] result_both_erase = 32'h00000003;
    localparam logic [31:0] result_verify = 32'h00000004;
    localparam logic [31:0] result_internal_verify = 32'h00000008;
    localparam logic [31:0] result_disabled = 32'h00000010;
    localparam logic [31:0] result_undefined = 32'hFFFFFFFF;

    // routine function numbers
    localparam logic [3:0] func_flash_info = 4'h0;
    localparam logic [3:0] func_erase_verify = 4'h1;
    localparam logic [3:0] func_erase_byte_verify = 4'h2;
    localparam logic [3:0] func_word_write = 4'h3;
    localparam logic [3:0] func_internal_verify = 4'h4;

    // flash information selectors
    localparam logic [31:0] info_offset_number = 32'h00000001;
    localparam logic [31:0] info_summary_selector = 32'h00000001;
    localparam logic [15:0] info_upper_field = 16'h0000;
    localparam logic [8:0] info_middle_field = 9'h002;
    localparam logic [6:0] info_lower_field = 7'h00;
    localparam logic [31:0] area0_end_address = 32'h0001FFFF;
    localparam logic [31:0] area1_end_address = 32'h0003FFFF;

    // cycles a routine takes before its result posts
    localparam logic [3:0] routine_cycles = 4'h4;

    typedef enum logic [1:0] {
        engine_idle,
        engine_busy,
        engine_done
    } engine_state_t;

endpackage : flash_self_program_pkg

/* File: core/pin_sync.sv */
// two-flop synchroniser for one asynchronous level
// assumes the destination clock is pclk
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
    input wire logic pclk, // clock
    input wire logic presetn, // async reset, active low
    input wire logic async_in, // level from outside
    output logic sync_out // synchronised level
);
    logic stage_one;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage_one <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            stage_one <= async_in;
            sync_out <= stage_one;
        end
    end
endmodule : pin_sync
`default_nettype wire

/* File: core/info_decoder.sv */
// flash information reply and result-code decode for the internal routines
// assumes inputs are stable while the routine engine is busy
`timescale 1ns/1ps
`default_nettype none
module info_decoder (
    input wire logic [3:0] function_number, // routine selected
    input wire logic [31:0] argument, // option selector or address
    input wire logic over_erase, // cell status: excessive erasure
    input wire logic under_erase, // cell status: blank check failed
    input wire logic readback_bad, // cell status: word readback mismatch
    input wire logic level_bad, // cell status: signal level low
    input wire logic writes_blocked, // program disable or no voltage
    output logic [31:0] result // value for the result register
);
    function automatic logic [31:0] info_reply(input logic [31:0] sel);
        if (sel == flash_self_program_pkg::info_summary_selector) begin
            info_reply = {flash_self_program_pkg::info_upper_field,
                          flash_self_program_pkg::info_middle_field,
                          flash_self_program_pkg::info_lower_field};
        end else if (sel == flash_self_program_pkg::info_offset_number + 32'h00000002) begin
            info_reply = flash_self_program_pkg::area0_end_address;
        end else if (sel == flash_self_program_pkg::info_offset_number + 32'h00000003) begin
            info_reply = flash_self_program_pkg::area1_end_address;
        end else begin
            info_reply = flash_self_program_pkg::result_undefined;
        end
    endfunction : info_reply

    always_comb begin
        case (function_number)
            flash_self_program_pkg::func_flash_info: begin
                result = info_reply(argument);
            end
            flash_self_program_pkg::func_erase_verify,
            flash_self_program_pkg::func_erase_byte_verify: begin
                if (over_erase && under_erase) begin
                    result = flash_self_program_pkg::result_both_erase;
                end else if (under_erase) begin
                    result = flash_self_program_pkg::result_undererase;
                end else if (over_erase) begin
                    result = flash_self_program_pkg::result_overerase;
                end else begin
                    result = flash_self_program_pkg::result_ok;
                end
            end
            flash_self_program_pkg::func_word_write: begin
                if (writes_blocked) begin
                    result = flash_self_program_pkg::result_disabled;
                end else if (readback_bad) begin
                    result = flash_self_program_pkg::result_verify;
                end else begin
                    result = flash_self_program_pkg::result_ok;
                end
            end
            flash_self_program_pkg::func_internal_verify: begin
                result = level_bad ? flash_self_program_pkg::result_internal_verify
                                   : flash_self_program_pkg::result_ok;
            end
            default: begin
                result = flash_self_program_pkg::result_undefined;
            end
        endcase
    end
endmodule : info_decoder
`default_nettype wire

/* File: core/flash_self_program_control.sv */
// flash self-programming mode control with protected write and routine engine
// assumes an apb master on pclk; voltage and mode pins are asynchronous
`timescale 1ns/1ps
`default_nettype none
module flash_self_program_control (
    input wire logic pclk, // apb clock
    input wire logic presetn, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [11:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    input wire logic [3:0] pstrb, // apb byte strobes
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error
    input wire logic program_voltage_pin, // programming voltage detect, async
    input wire logic programmer_mode_pin, // on-board programmer mode, async
    input wire logic interrupt_accepted, // cpu took an interrupt this cycle
    input wire logic dma_accepted, // dma request granted this cycle
    output logic self_program_active, // fetch from self-programming interface
    output logic flash_write_enable, // flash write and erase permitted
    output logic routine_busy // internal routine running
);
    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic voltage_present;
    logic programmer_mode;

    pin_sync voltage_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(program_voltage_pin),
        .sync_out(voltage_present)
    );

    pin_sync programmer_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(programmer_mode_pin),
        .sync_out(programmer_mode)
    );

    ////////////////////////////////////////////////////////////////////////
    // bus decode
    logic access_phase;
    logic write_done;
    logic hit_command;
    logic hit_mode;
    logic hit_status;
    logic hit_request;
    logic hit_argument;
    logic hit_result;
    logic hit_cells;
    logic hit_any;

    assign access_phase = psel && penable;
    assign write_done = access_phase && pwrite;
    assign hit_command = paddr == flash_self_program_pkg::protect_command_offset;
    assign hit_mode = paddr == flash_self_program_pkg::mode_control_offset;
    assign hit_status = paddr == flash_self_program_pkg::system_status_offset;
    assign hit_request = paddr == flash_self_program_pkg::routine_request_offset;
    assign hit_argument = paddr == flash_self_program_pkg::routine_argument_offset;
    assign hit_result = paddr == flash_self_program_pkg::routine_result_offset;
    assign hit_cells = paddr == flash_self_program_pkg::cell_status_offset;
    assign hit_any = hit_command || hit_mode || hit_status || hit_request
                     || hit_argument || hit_result || hit_cells;

    ////////////////////////////////////////////////////////////////////////
    // unlock sequencing
    logic unlock_armed;
    logic broken_sequence;
    logic mode_write_ok;
    logic mode_write_dropped;

    assign broken_sequence = interrupt_accepted || dma_accepted;
    assign mode_write_ok = write_done && hit_mode && pstrb[0] && unlock_armed
                           && !broken_sequence;
    assign mode_write_dropped = write_done && hit_mode && (!unlock_armed || broken_sequence);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            unlock_armed <= 1'b0;
        end else if (write_done && hit_command && pstrb[0]) begin
            unlock_armed <= 1'b1;
        end else if (write_done || broken_sequence) begin
            unlock_armed <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // mode control register, writable bits only
    logic [7:0] mode_bits;
    logic [7:0] mode_read;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_bits <= flash_self_program_pkg::mode_control_reset;
        end else if (mode_write_ok) begin
            mode_bits <= (pwdata[7:0] & flash_self_program_pkg::mode_control_write_mask)
                         | (flash_self_program_pkg::mode_control_reset
                            & ~flash_self_program_pkg::mode_control_write_mask);
        end
    end

    always_comb begin
        mode_read = mode_bits;
        mode_read[flash_self_program_pkg::voltage_detect_bit] = voltage_present;
    end

    ////////////////////////////////////////////////////////////////////////
    // protection error flag, set wins over clear
    logic protection_error;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            protection_error <= 1'b0;
        end else if (mode_write_dropped) begin
            protection_error <= 1'b1;
        end else if (write_done && hit_status && pstrb[0]
                     && pwdata[flash_self_program_pkg::protection_error_pos]) begin
            protection_error <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // mode outputs
    logic self_program_allowed;
    logic writes_blocked;

    assign self_program_allowed = mode_bits[flash_self_program_pkg::self_program_bit]
                                  && voltage_present && !programmer_mode;
    assign writes_blocked = mode_bits[flash_self_program_pkg::program_disable_bit_pos]
                            || !voltage_present;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            self_program_active <= 1'b0;
            flash_write_enable <= 1'b0;
        end else begin
            self_program_active <= self_program_allowed;
            flash_write_enable <= !writes_blocked;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // routine engine: request register holds the function number,
    // argument holds the second argument, cell status stands in for the array
    logic [3:0] function_number;
    logic [31:0] argument;
    logic [3:0] cell_status;
    logic [31:0] result;
    logic [31:0] next_result;
    logic [3:0] cycle_count;
    flash_self_program_pkg::engine_state_t engine_state;

    info_decoder decoder (
        .function_number(function_number),
        .argument(argument),
        .over_erase(cell_status[0]),
        .under_erase(cell_status[1]),
        .readback_bad(cell_status[2]),
        .level_bad(cell_status[3]),
        .writes_blocked(writes_blocked),
        .result(next_result)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            argument <= 32'h00000000;
            cell_status <= 4'h0;
        end else if (write_done && engine_state != flash_self_program_pkg::engine_busy) begin
            if (hit_argument) begin
                argument <= pwdata;
            end
            if (hit_cells) begin
                cell_status <= pwdata[3:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            engine_state <= flash_self_program_pkg::engine_idle;
            function_number <= 4'h0;
            cycle_count <= 4'h0;
            result <= flash_self_program_pkg::result_ok;
        end else begin
            case (engine_state)
                flash_self_program_pkg::engine_idle,
                flash_self_program_pkg::engine_done: begin
                    if (write_done && hit_request && self_program_active) begin
                        function_number <= pwdata[3:0];
                        cycle_count <= flash_self_program_pkg::routine_cycles;
                        engine_state <= flash_self_program_pkg::engine_busy;
                    end
                end
                flash_self_program_pkg::engine_busy: begin
                    if (cycle_count == 4'h1) begin
                        result <= next_result;
                        engine_state <= flash_self_program_pkg::engine_done;
                    end
                    cycle_count <= cycle_count - 4'h1;
                end
                default: begin
                    engine_state <= flash_self_program_pkg::engine_idle;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            routine_busy <= 1'b0;
        end else begin
            routine_busy <= (engine_state == flash_self_program_pkg::engine_busy && cycle_count != 4'h1)
                            || (engine_state != flash_self_program_pkg::engine_busy
                                && write_done && hit_request && self_program_active);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // apb read data and answer
    logic [31:0] read_value;

    always_comb begin
        read_value = 32'h00000000;
        if (hit_mode) begin
            read_value = {24'h000000, mode_read};
        end else if (hit_status) begin
            read_value = {31'h00000000, protection_error};
        end else if (hit_request) begin
            read_value = {28'h0000000, function_number};
        end else if (hit_argument) begin
            read_value = argument;
        end else if (hit_result) begin
            read_value = result;
        end else if (hit_cells) begin
            read_value = {28'h0000000, cell_status};
        end
    end

    // zero wait states: ready is registered high from reset release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else begin
            prdata <= (psel && !penable && !pwrite) ? read_value : prdata;
            pslverr <= psel && !penable && !hit_any;
        end
    end
endmodule : flash_self_program_control
`default_nettype wire

/* File: bench/flash_self_program_monitor.sv */
// port checker for the flash self-programming control block
// assumes it is bound to flash_self_program_control on pclk
`timescale 1ns/1ps
`default_nettype none
module flash_self_program_monitor (
    input wire logic pclk, // clock
    input wire logic presetn, // reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [11:0] paddr, // apb address
    input wire logic [31:0] prdata, // apb read data
    input wire logic pready, // apb ready
    input wire logic pslverr, // apb error
    input wire logic program_voltage_pin, // voltage level
    input wire logic programmer_mode_pin, // programmer level
    input wire logic self_program_active, // self-program fetch
    input wire logic flash_write_enable, // write permit
    input wire logic routine_busy // routine running
);
    logic request_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            request_q <= 1'b0;
        end else begin
            request_q <= psel && penable && pwrite && paddr == flash_self_program_pkg::routine_request_offset;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence setup_s; psel && !penable; endsequence
    sequence busy_run_s; routine_busy [*4] ##1 !routine_busy; endsequence
    ////////////////////////////////////////////////////////////////
    a_ready_zero_wait: assert property (setup_s |=> pready)
        else $error("ready not given after setup");
    a_prdata_holds: assert property (!(psel && !penable) |=> $stable(prdata))
        else $error("read data moved outside setup");
    a_unmapped_err: assert property (psel && penable && paddr > flash_self_program_pkg::cell_status_offset |-> pslverr)
        else $error("unmapped access not flagged");
    a_err_in_access: assert property (pslverr |-> psel && penable)
        else $error("error outside access phase");
    a_busy_length: assert property ($rose(routine_busy) |-> busy_run_s)
        else $error("routine busy length wrong");
    a_busy_cause: assert property ($rose(routine_busy) |-> request_q)
        else $error("routine started without request");
    a_programmer_blocks: assert property (programmer_mode_pin [*4] |-> !self_program_active)
        else $error("self-program active under programmer");
    a_no_voltage_off: assert property (!program_voltage_pin [*4] |-> !self_program_active && !flash_write_enable)
        else $error("active without voltage");
endmodule : flash_self_program_monitor
bind flash_self_program_control flash_self_program_monitor mon (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .program_voltage_pin(program_voltage_pin), .programmer_mode_pin(programmer_mode_pin),
    .self_program_active(self_program_active), .flash_write_enable(flash_write_enable), .routine_busy(routine_busy));
`default_nettype wire

/* File: bench/cpu_side_model.sv */
// model of the cpu side pins: voltage, programmer mode, interrupt and dma grants
// assumes the bench requests levels and single grant pulses on pclk
`timescale 1ns/1ps
`default_nettype none
module cpu_side_model (
    input wire logic pclk, // clock
    input wire logic presetn, // reset, active low
    input wire logic want_voltage, // apply programming voltage
    input wire logic want_programmer, // enter programmer mode
    input wire logic fire_interrupt, // let one interrupt through
    input wire logic fire_dma, // let one dma grant through
    output logic program_voltage_pin, // voltage level
    output logic programmer_mode_pin, // programmer level
    output logic interrupt_accepted, // interrupt grant pulse
    output logic dma_accepted // dma grant pulse
);
    assign program_voltage_pin = want_voltage;
    assign programmer_mode_pin = want_programmer;
    // grants stay masked unless a scenario opens them for one cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            interrupt_accepted <= 1'b0;
            dma_accepted <= 1'b0;
        end else begin
            interrupt_accepted <= fire_interrupt;
            dma_accepted <= fire_dma;
        end
    end
endmodule : cpu_side_model
`default_nettype wire

/* File: bench/test_flash_self_program_control.sv */
// self-checking bench for the flash self-programming control block
// assumes apb zero-wait slave and a cpu side model for pins and grants
`timescale 1ns/1ps
`default_nettype none
module test_flash_self_program_control;
    localparam logic [11:0] cmd_a = flash_self_program_pkg::protect_command_offset;
    localparam logic [11:0] mode_a = flash_self_program_pkg::mode_control_offset;
    localparam logic [11:0] stat_a = flash_self_program_pkg::system_status_offset;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [3:0] pstrb = 4'hF;
    logic [31:0] prdata;
    logic pready, pslverr, volt_pin, prog_pin, irq, dma, spa, fwe, busy;
    logic want_voltage = 1'b0;
    logic want_programmer = 1'b0;
    logic fire [2] = '{1'b0, 1'b0};
    logic [31:0] rd;
    int failures = 0;
    int n_tests = 0;
    int cycles = 0;
    always #5 pclk = ~pclk;
    flash_self_program_control dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .program_voltage_pin(volt_pin), .programmer_mode_pin(prog_pin), .interrupt_accepted(irq),
        .dma_accepted(dma), .self_program_active(spa), .flash_write_enable(fwe), .routine_busy(busy));
    cpu_side_model cpu (.pclk(pclk), .presetn(presetn), .want_voltage(want_voltage),
        .want_programmer(want_programmer), .fire_interrupt(fire[0]), .fire_dma(fire[1]),
        .program_voltage_pin(volt_pin), .programmer_mode_pin(prog_pin), .interrupt_accepted(irq), .dma_accepted(dma));
    ////////////////////////////////////////////////////////////////
    task finish_test;
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : finish_test
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            finish_test;
        end
    end
    task check(input string n, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            failures++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : check
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        apb(1'b1, a, d, r);
    endtask : wr
    task expect_reg(input string n, input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h00000000, rd);
        check(n, e, rd & m);
    endtask : expect_reg
    task mode_write(input logic [7:0] d);
        wr(cmd_a, 32'h000000A5);
        wr(mode_a, {24'h000000, d});
        repeat (5) @(posedge pclk);
    endtask : mode_write
    task routine(input logic [3:0] f, input logic [31:0] a, input logic [3:0] c, input logic [31:0] e);
        int w;
        wr(flash_self_program_pkg::routine_argument_offset, a);
        wr(flash_self_program_pkg::cell_status_offset, {28'h0000000, c});
        wr(flash_self_program_pkg::routine_request_offset, {28'h0000000, f});
        @(posedge pclk);
        w = 0;
        while (busy !== 1'b0 && w < 50) begin
            @(posedge pclk);
            w++;
        end
        check("routine done", 32'h0, {31'h0, busy});
        expect_reg("routine result", flash_self_program_pkg::routine_result_offset, 32'hFFFFFFFF, e);
    endtask : routine
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        expect_reg("mode at reset", mode_a, 32'hFFFFFFFF, 32'h00000018);
        want_voltage <= 1'b1;
        repeat (5) @(posedge pclk);
        expect_reg("mode with voltage", mode_a, 32'h000000FF, 32'h0000001C);
        wr(mode_a, 32'h00000012);
        expect_reg("mode unlocked only", mode_a, 32'h000000FF, 32'h0000001C);
        expect_reg("protection error", stat_a, 32'h00000001, 32'h00000001);
        wr(stat_a, 32'h00000001);
        expect_reg("error cleared", stat_a, 32'h00000001, 32'h00000000);
        for (int i = 0; i < 2; i++) begin
            wr(cmd_a, 32'h00000000);
            fire[i] <= 1'b1;
            @(posedge pclk);
            fire[i] <= 1'b0;
            wr(mode_a, 32'h00000012);
            expect_reg("mode after grant", mode_a, 32'h000000FF, 32'h0000001C);
            expect_reg("grant error", stat_a, 32'h00000001, 32'h00000001);
            wr(stat_a, 32'h00000001);
        end
        wr(cmd_a, 32'h00000000);
        wr(flash_self_program_pkg::routine_argument_offset, 32'h00000001);
        wr(mode_a, 32'h00000012);
        expect_reg("unlock consumed", mode_a, 32'h000000FF, 32'h0000001C);
        mode_write(8'h1E);
        expect_reg("mode disabled", mode_a, 32'h000000FF, 32'h0000001E);
        check("write enable off", 32'h0, {31'h0, fwe});
        check("self program on", 32'h1, {31'h0, spa});
        routine(flash_self_program_pkg::func_word_write, 32'h0, 4'h0, flash_self_program_pkg::result_disabled);
        mode_write(8'h12);
        expect_reg("mode enabled", mode_a, 32'h000000FF, 32'h00000016);
        check("write enable on", 32'h1, {31'h0, fwe});
        routine(flash_self_program_pkg::func_flash_info, 32'h1, 4'h0, {flash_self_program_pkg::info_upper_field,
            flash_self_program_pkg::info_middle_field, flash_self_program_pkg::info_lower_field});
        routine(flash_self_program_pkg::func_flash_info, 32'h3, 4'h0, flash_self_program_pkg::area0_end_address);
        routine(flash_self_program_pkg::func_flash_info, 32'h4, 4'h0, flash_self_program_pkg::area1_end_address);
        routine(flash_self_program_pkg::func_flash_info, 32'h9, 4'h0, flash_self_program_pkg::result_undefined);
        routine(flash_self_program_pkg::func_erase_verify, 32'h0, 4'h1, flash_self_program_pkg::result_overerase);
        routine(flash_self_program_pkg::func_erase_verify, 32'h0, 4'h3, flash_self_program_pkg::result_both_erase);
        routine(flash_self_program_pkg::func_erase_byte_verify, 32'h0, 4'h2,
            flash_self_program_pkg::result_undererase);
        routine(flash_self_program_pkg::func_word_write, 32'h0, 4'h4, flash_self_program_pkg::result_verify);
        routine(flash_self_program_pkg::func_internal_verify, 32'h0, 4'h8,
            flash_self_program_pkg::result_internal_verify);
        routine(flash_self_program_pkg::func_internal_verify, 32'h0, 4'h0, flash_self_program_pkg::result_ok);
        wr(12'h020, 32'h00000000);
        want_programmer <= 1'b1;
        repeat (5) @(posedge pclk);
        check("programmer mode", 32'h0, {31'h0, spa});
        want_programmer <= 1'b0;
        want_voltage <= 1'b0;
        repeat (5) @(posedge pclk);
        check("no voltage", 32'h0, {31'h0, spa | fwe});
        finish_test;
    end
endmodule : test_flash_self_program_control
`default_nettype wire
